// *** common/dtc_pkg.sv ***
// Constants, field positions and encodings shared by the dual timer/counter control block.
package dtc_pkg;

  // ******************************************************************
  // Register addresses
  // ******************************************************************
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE    = 8'h89;
  localparam logic [7:0] ADDR_TIMER_A_LOW   = 8'h8A;
  localparam logic [7:0] ADDR_TIMER_B_LOW   = 8'h8B;
  localparam logic [7:0] ADDR_TIMER_A_HIGH  = 8'h8C;
  localparam logic [7:0] ADDR_TIMER_B_HIGH  = 8'h8D;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ******************************************************************
  // Control register bit positions
  // ******************************************************************
  localparam int unsigned CTL_B_OVF  = 7;
  localparam int unsigned CTL_B_RUN  = 6;
  localparam int unsigned CTL_A_OVF  = 5;
  localparam int unsigned CTL_A_RUN  = 4;
  localparam int unsigned CTL_XB_FLG = 3;
  localparam int unsigned CTL_XB_EDG = 2;
  localparam int unsigned CTL_XA_FLG = 1;
  localparam int unsigned CTL_XA_EDG = 0;

  // ******************************************************************
  // Mode register bit positions
  // ******************************************************************
  localparam int unsigned MOD_B_GATE = 7;
  localparam int unsigned MOD_B_CSEL = 6;
  localparam int unsigned MOD_B_MHI  = 5;
  localparam int unsigned MOD_B_MLO  = 4;
  localparam int unsigned MOD_A_GATE = 3;
  localparam int unsigned MOD_A_CSEL = 2;
  localparam int unsigned MOD_A_MHI  = 1;
  localparam int unsigned MOD_A_MLO  = 0;

  // ******************************************************************
  // Counter layout
  // ******************************************************************
  localparam int unsigned LOW13_W = 5;

  typedef enum logic [1:0] {
    DTC_MODE_13     = 2'b00,
    DTC_MODE_16     = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT  = 2'b11
  } dtc_mode_e;

  // ******************************************************************
  // Prescaler
  // ******************************************************************
  typedef enum logic [1:0] {
    DTC_PRE_DIV12 = 2'b00,
    DTC_PRE_DIV4  = 2'b01,
    DTC_PRE_DIV48 = 2'b10,
    DTC_PRE_EXT8  = 2'b11
  } dtc_prescale_e;

  localparam int unsigned PRE_CNT_W = 6;
  localparam logic [PRE_CNT_W-1:0] PRE_DIV12_LAST = 6'h0B;
  localparam logic [PRE_CNT_W-1:0] PRE_DIV4_LAST  = 6'h03;
  localparam logic [PRE_CNT_W-1:0] PRE_DIV48_LAST = 6'h2F;
  localparam logic [PRE_CNT_W-1:0] PRE_EXT8_LAST  = 6'h07;
  localparam logic [PRE_CNT_W-1:0] PRE_ZERO       = 6'h00;
  localparam logic [PRE_CNT_W-1:0] PRE_ONE        = 6'h01;

endpackage : dtc_pkg

// *** rtl/dtc_sync_edge.sv ***
// Two-flop synchroniser with level and edge outputs for one input pin.
`timescale 1ns/1ps
module dtc_sync_edge
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      fall,
  output logic      rise
);

  logic meta;
  logic sync;
  logic prev;

  // ******************************************************************
  // Synchroniser
  // ******************************************************************
  // The first stage feeds only the second, so no logic sees a metastable value.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level = sync;
  assign fall  = prev & ~sync;
  assign rise  = ~prev & sync;

endmodule : dtc_sync_edge

// *** rtl/dtc_prescaler.sv ***
// Shared prescaler producing the timer clock tick for both timers.
`timescale 1ns/1ps
module dtc_prescaler
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire dtc_pkg::dtc_prescale_e sel,
  input  wire logic                  ext_clk_in,
  output logic                       tick
);

  logic [dtc_pkg::PRE_CNT_W-1:0] count;
  logic [dtc_pkg::PRE_CNT_W-1:0] last;
  logic                          ext_fall;
  logic                          step;
  logic                          wrap;

  dtc_sync_edge u_ext_sync
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (ext_clk_in),
    .level   (),
    .fall    (ext_fall),
    .rise    ()
  );

  // ******************************************************************
  // Divider
  // ******************************************************************
  // divide ratio select
  always_comb
  begin
    unique case (sel)
      dtc_pkg::DTC_PRE_DIV12: last = dtc_pkg::PRE_DIV12_LAST;
      dtc_pkg::DTC_PRE_DIV4:  last = dtc_pkg::PRE_DIV4_LAST;
      dtc_pkg::DTC_PRE_DIV48: last = dtc_pkg::PRE_DIV48_LAST;
      dtc_pkg::DTC_PRE_EXT8:  last = dtc_pkg::PRE_EXT8_LAST;
    endcase
  end

  // The external clock is counted by its synchronised falling edges.
  assign step = (sel == dtc_pkg::DTC_PRE_EXT8) ? ext_fall : 1'b1;
  // A ratio change mid-period can leave the count above the new limit.
  assign wrap = step & (count >= last);
  assign tick = wrap;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      count <= dtc_pkg::PRE_ZERO;
    else if (wrap)
      count <= dtc_pkg::PRE_ZERO;
    else if (step)
      count <= count + dtc_pkg::PRE_ONE;
  end

endmodule : dtc_prescaler

// *** rtl/dtc_top.sv ***
// Dual timer/counter control, mode, count registers and external interrupt flags.
`timescale 1ns/1ps
module dtc_top
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic [7:0]             sfr_addr,
  input  wire logic                   sfr_wr,
  input  wire logic                   sfr_rd,
  input  wire logic [7:0]             sfr_wdata,
  output logic      [7:0]             sfr_rdata,
  input  wire logic                   count_pin_a,
  input  wire logic                   count_pin_b,
  input  wire logic                   ext_irq_a_input,
  input  wire logic                   ext_irq_b_input,
  input  wire logic                   ext_irq_a_polarity,
  input  wire logic                   ext_irq_b_polarity,
  input  wire dtc_pkg::dtc_prescale_e prescale_select,
  input  wire logic                   timer_a_sysclk_select,
  input  wire logic                   timer_b_sysclk_select,
  input  wire logic                   ext_clk_in,
  input  wire logic                   vector_timer_a,
  input  wire logic                   vector_timer_b,
  input  wire logic                   vector_ext_irq_a,
  input  wire logic                   vector_ext_irq_b,
  output logic                        timer_a_overflow_flag,
  output logic                        timer_b_overflow_flag,
  output logic                        ext_irq_a_flag,
  output logic                        ext_irq_b_flag,
  output logic                        timer_b_overflow_pulse
);

  // ******************************************************************
  // Registers
  // ******************************************************************
  logic [7:0] timer_control;
  logic [7:0] timer_mode;
  logic [7:0] timer_a_low_byte;
  logic [7:0] timer_b_low_byte;
  logic [7:0] timer_a_high_byte;
  logic [7:0] timer_b_high_byte;
  logic       b_ovf_pulse;

  logic [7:0] next_timer_control;
  logic [7:0] next_timer_a_low_byte;
  logic [7:0] next_timer_b_low_byte;
  logic [7:0] next_timer_a_high_byte;
  logic [7:0] next_timer_b_high_byte;
  logic [7:0] next_rdata;

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  logic [3:0] pin_raw;
  logic [3:0] pin_level;
  logic [3:0] pin_fall;
  logic [3:0] pin_rise;

  assign pin_raw = {ext_irq_b_input, ext_irq_a_input, count_pin_b, count_pin_a};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pin
      dtc_sync_edge u_sync
      (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin     (pin_raw[gi]),
        .level   (pin_level[gi]),
        .fall    (pin_fall[gi]),
        .rise    (pin_rise[gi])
      );
    end
  endgenerate

  wire count_a_fall = pin_fall[0];
  wire count_b_fall = pin_fall[1];

  // ******************************************************************
  // Prescaler
  // ******************************************************************
  logic pre_tick;

  dtc_prescaler u_prescaler
  (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .sel        (prescale_select),
    .ext_clk_in (ext_clk_in),
    .tick       (pre_tick)
  );

  // ******************************************************************
  // Field decode
  // ******************************************************************
  wire timer_b_run           = timer_control[dtc_pkg::CTL_B_RUN];
  wire timer_a_run           = timer_control[dtc_pkg::CTL_A_RUN];
  wire ext_irq_b_edge_select = timer_control[dtc_pkg::CTL_XB_EDG];
  wire ext_irq_a_edge_select = timer_control[dtc_pkg::CTL_XA_EDG];

  wire timer_b_gating         = timer_mode[dtc_pkg::MOD_B_GATE];
  wire timer_b_counter_select = timer_mode[dtc_pkg::MOD_B_CSEL];
  wire timer_a_gating         = timer_mode[dtc_pkg::MOD_A_GATE];
  wire timer_a_counter_select = timer_mode[dtc_pkg::MOD_A_CSEL];

  dtc_pkg::dtc_mode_e timer_a_mode_field;
  dtc_pkg::dtc_mode_e timer_b_mode_field;
  assign timer_a_mode_field =
    dtc_pkg::dtc_mode_e'(timer_mode[dtc_pkg::MOD_A_MHI:dtc_pkg::MOD_A_MLO]);
  assign timer_b_mode_field =
    dtc_pkg::dtc_mode_e'(timer_mode[dtc_pkg::MOD_B_MHI:dtc_pkg::MOD_B_MLO]);

  wire a_split = (timer_a_mode_field == dtc_pkg::DTC_MODE_SPLIT);

  // ******************************************************************
  // Register write decode
  // ******************************************************************
  wire wr_ctl    = sfr_wr & (sfr_addr == dtc_pkg::ADDR_TIMER_CONTROL);
  wire wr_mode   = sfr_wr & (sfr_addr == dtc_pkg::ADDR_TIMER_MODE);
  wire wr_a_low  = sfr_wr & (sfr_addr == dtc_pkg::ADDR_TIMER_A_LOW);
  wire wr_b_low  = sfr_wr & (sfr_addr == dtc_pkg::ADDR_TIMER_B_LOW);
  wire wr_a_high = sfr_wr & (sfr_addr == dtc_pkg::ADDR_TIMER_A_HIGH);
  wire wr_b_high = sfr_wr & (sfr_addr == dtc_pkg::ADDR_TIMER_B_HIGH);

  // ******************************************************************
  // External interrupt sensing
  // ******************************************************************
  // Polarity high means the input is active high.
  wire xa_active = ext_irq_a_polarity ? pin_level[2] : ~pin_level[2];
  wire xb_active = ext_irq_b_polarity ? pin_level[3] : ~pin_level[3];
  wire xa_edge   = ext_irq_a_polarity ? pin_rise[2] : pin_fall[2];
  wire xb_edge   = ext_irq_b_polarity ? pin_rise[3] : pin_fall[3];

  wire xa_set = ext_irq_a_edge_select ? xa_edge : xa_active;
  wire xb_set = ext_irq_b_edge_select ? xb_edge : xb_active;

  // ******************************************************************
  // Counter step function
  // ******************************************************************
  // Returns {overflow, high, low} after one increment in the given mode.
  function automatic logic [16:0] dtc_step
  (
    input dtc_pkg::dtc_mode_e mode,
    input logic [7:0]         hi,
    input logic [7:0]         lo
  );
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0]  c8;
    c13 = {1'b0, hi, lo[dtc_pkg::LOW13_W-1:0]} + 14'h0001;
    c16 = {1'b0, hi, lo} + 17'h00001;
    c8  = {1'b0, lo} + 9'h001;
    unique case (mode)
      dtc_pkg::DTC_MODE_13:
        dtc_step = {c13[13], c13[12:5], lo[7:dtc_pkg::LOW13_W], c13[4:0]};
      dtc_pkg::DTC_MODE_16:
        dtc_step = c16;
      dtc_pkg::DTC_MODE_RELOAD:
        dtc_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
      dtc_pkg::DTC_MODE_SPLIT:
        dtc_step = {c8[8], hi, c8[7:0]};
    endcase
  endfunction : dtc_step

  // ******************************************************************
  // Timer A
  // ******************************************************************
  // timer A gating
  wire a_enable = timer_a_run & (~timer_a_gating | xa_active);
  wire a_clock  = timer_a_sysclk_select | pre_tick;
  wire a_tick   = timer_a_counter_select ? count_a_fall : a_clock;
  wire a_inc    = a_enable & a_tick;

  logic [16:0] a_step;
  assign a_step = dtc_step(timer_a_mode_field, timer_a_high_byte, timer_a_low_byte);
  wire a_ovf_evt = a_inc & a_step[16];

  // split high byte on B run
  wire       ah_inc     = a_split & timer_b_run & a_clock;
  wire [8:0] ah_sum     = {1'b0, timer_a_high_byte} + 9'h001;
  wire       ah_ovf_evt = ah_inc & ah_sum[8];

  // ******************************************************************
  // Timer B
  // ******************************************************************
  // While A is split, B runs by its mode alone and takes no pin count.
  wire b_active = (timer_b_mode_field != dtc_pkg::DTC_MODE_SPLIT);
  wire b_gate_ok = ~timer_b_gating | xb_active;
  wire b_enable = b_active & (a_split | (timer_b_run & b_gate_ok));
  wire b_clock  = timer_b_sysclk_select | pre_tick;
  wire b_tick   = (timer_b_counter_select & ~a_split) ? count_b_fall : b_clock;
  wire b_inc    = b_enable & b_tick;

  logic [16:0] b_step;
  assign b_step = dtc_step(timer_b_mode_field, timer_b_high_byte, timer_b_low_byte);
  wire b_ovf_evt = b_inc & b_step[16];

  wire b_flag_set = a_split ? ah_ovf_evt : b_ovf_evt;

  // ******************************************************************
  // Next count values
  // ******************************************************************
  // A write to a byte takes precedence over a count on the same byte.
  // low bytes writable anytime
  assign next_timer_a_low_byte = wr_a_low ? sfr_wdata :
                                 a_inc    ? a_step[7:0] : timer_a_low_byte;
  assign next_timer_b_low_byte = wr_b_low ? sfr_wdata :
                                 b_inc    ? b_step[7:0] : timer_b_low_byte;

  assign next_timer_a_high_byte = wr_a_high ? sfr_wdata :
                                  a_split   ? (ah_inc ? ah_sum[7:0] : timer_a_high_byte) :
                                  a_inc     ? a_step[15:8] : timer_a_high_byte;
  assign next_timer_b_high_byte = wr_b_high ? sfr_wdata :
                                  b_inc     ? b_step[15:8] : timer_b_high_byte;

  // ******************************************************************
  // Control register update
  // ******************************************************************
  logic [7:0] ctl_written;
  logic [7:0] ctl_clear;
  logic [7:0] ctl_set;

  assign ctl_written = wr_ctl ? sfr_wdata : timer_control;

  // B cleared on vector if edge
  // A cleared on vector if edge
  always_comb
  begin
    ctl_clear = dtc_pkg::REG_RESET;
    ctl_clear[dtc_pkg::CTL_B_OVF]  = vector_timer_b;
    ctl_clear[dtc_pkg::CTL_A_OVF]  = vector_timer_a;
    ctl_clear[dtc_pkg::CTL_XB_FLG] = vector_ext_irq_b & ext_irq_b_edge_select;
    ctl_clear[dtc_pkg::CTL_XA_FLG] = vector_ext_irq_a & ext_irq_a_edge_select;
  end

  always_comb
  begin
    ctl_set = dtc_pkg::REG_RESET;
    ctl_set[dtc_pkg::CTL_B_OVF]  = b_flag_set;
    ctl_set[dtc_pkg::CTL_A_OVF]  = a_ovf_evt;
    ctl_set[dtc_pkg::CTL_XB_FLG] = xb_set;
    ctl_set[dtc_pkg::CTL_XA_FLG] = xa_set;
  end

  assign next_timer_control = (ctl_written & ~ctl_clear) | ctl_set;

  // ******************************************************************
  // Read data
  // ******************************************************************
  always_comb
  begin
    unique case (sfr_addr)
      dtc_pkg::ADDR_TIMER_CONTROL: next_rdata = timer_control;
      dtc_pkg::ADDR_TIMER_MODE:    next_rdata = timer_mode;
      dtc_pkg::ADDR_TIMER_A_LOW:   next_rdata = timer_a_low_byte;
      dtc_pkg::ADDR_TIMER_B_LOW:   next_rdata = timer_b_low_byte;
      dtc_pkg::ADDR_TIMER_A_HIGH:  next_rdata = timer_a_high_byte;
      dtc_pkg::ADDR_TIMER_B_HIGH:  next_rdata = timer_b_high_byte;
      default:                     next_rdata = dtc_pkg::RDATA_UNMAPPED;
    endcase
  end

  // ******************************************************************
  // State registers
  // ******************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      timer_control     <= dtc_pkg::REG_RESET;
      timer_mode        <= dtc_pkg::REG_RESET;
      timer_a_low_byte  <= dtc_pkg::REG_RESET;
      timer_b_low_byte  <= dtc_pkg::REG_RESET;
      timer_a_high_byte <= dtc_pkg::REG_RESET;
      timer_b_high_byte <= dtc_pkg::REG_RESET;
    end
    else
    begin
      timer_control     <= next_timer_control;
      timer_mode        <= wr_mode ? sfr_wdata : timer_mode;
      timer_a_low_byte  <= next_timer_a_low_byte;
      timer_b_low_byte  <= next_timer_b_low_byte;
      timer_a_high_byte <= next_timer_a_high_byte;
      timer_b_high_byte <= next_timer_b_high_byte;
    end
  end

  // Read data holds its last value between reads, so a slow core may sample late.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sfr_rdata   <= dtc_pkg::RDATA_UNMAPPED;
      b_ovf_pulse <= 1'b0;
    end
    else
    begin
      if (sfr_rd)
        sfr_rdata <= next_rdata;
      b_ovf_pulse <= b_ovf_evt;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign timer_a_overflow_flag  = timer_control[dtc_pkg::CTL_A_OVF];
  assign timer_b_overflow_flag  = timer_control[dtc_pkg::CTL_B_OVF];
  assign ext_irq_a_flag         = timer_control[dtc_pkg::CTL_XA_FLG];
  assign ext_irq_b_flag         = timer_control[dtc_pkg::CTL_XB_FLG];
  // Timer B overflow still reaches other users while its flag is taken by split mode.
  assign timer_b_overflow_pulse = b_ovf_pulse;

endmodule : dtc_top

// *** tb/dtc_props.sv ***
// Concurrent checks on the ports of the dual timer/counter control block.
`timescale 1ns/1ps
module dtc_props
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       ext_irq_a_input,
  input wire logic       ext_irq_a_polarity,
  input wire logic       vector_timer_a,
  input wire logic       vector_ext_irq_a,
  input wire logic       timer_a_overflow_flag,
  input wire logic       timer_b_overflow_flag,
  input wire logic       ext_irq_a_flag,
  input wire logic       timer_b_overflow_pulse
);
  // ****************************************
  // Port relations
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic ctl_wr;
  logic act_a;
  assign ctl_wr = sfr_wr && (sfr_addr == 8'h88);
  assign act_a  = ext_irq_a_input == ext_irq_a_polarity;
  a_reset_clears_all: assert property (disable iff (1'b0) rst |=>
    sfr_rdata == 8'h00 && !timer_a_overflow_flag && !ext_irq_a_flag)
    else $error("state not cleared by reset");
  a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (sfr_rd && (sfr_addr < 8'h88 || sfr_addr > 8'h8D)
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_sw_sets_flags: assert property (ctl_wr |=> ($past(sfr_wdata[7]) -> timer_b_overflow_flag)
    && ($past(sfr_wdata[5]) -> timer_a_overflow_flag)) else $error("flag write lost");
  a_ctl_readback: assert property (sfr_rd && sfr_addr == 8'h88 |=>
    sfr_rdata[5] == $past(timer_a_overflow_flag) && sfr_rdata[1] == $past(ext_irq_a_flag))
    else $error("control read differs from flags");
  a_flag_a_fall: assert property ($fell(timer_a_overflow_flag) |-> $past(vector_timer_a)
    || ($past(ctl_wr) && !$past(sfr_wdata[5]))) else $error("overflow flag fell uncaused");
  a_ext_a_fall: assert property ($fell(ext_irq_a_flag) |-> $past(vector_ext_irq_a)
    || ($past(ctl_wr) && !$past(sfr_wdata[1]))) else $error("irq flag fell uncaused");
  a_ext_a_rise: assert property ($rose(ext_irq_a_flag) |-> ($past(ctl_wr) && $past(sfr_wdata[1]))
    || $past(act_a, 2) || $past(act_a, 3) || $past(act_a, 4) || $past(act_a, 5))
    else $error("irq flag rose without active input");
  c_b_overflow: cover property (timer_b_overflow_pulse);
  c_irq_rise: cover property ($rose(ext_irq_a_flag));
  c_flag_clear: cover property ($fell(timer_a_overflow_flag));
endmodule : dtc_props
bind dtc_top dtc_props u_dtc_props
(
  .sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext_irq_a_input(ext_irq_a_input),
  .ext_irq_a_polarity(ext_irq_a_polarity), .vector_timer_a(vector_timer_a),
  .vector_ext_irq_a(vector_ext_irq_a), .timer_a_overflow_flag(timer_a_overflow_flag),
  .timer_b_overflow_flag(timer_b_overflow_flag), .ext_irq_a_flag(ext_irq_a_flag),
  .timer_b_overflow_pulse(timer_b_overflow_pulse)
);

// *** tb/dtc_pin_model.sv ***
// Behavioural driver of the two external count pins.
`timescale 1ns/1ps
module dtc_pin_model
(
  input wire logic sys_clk,
  output logic     count_pin_a,
  output logic     count_pin_b
);
  // ****************************************
  // Pin pulses
  // ****************************************
  initial
  begin
    count_pin_a = 1'b1;
    count_pin_b = 1'b1;
  end
  task automatic drive(input int pin, input logic v, input int gap);
    @(posedge sys_clk);
    #1 if (pin == 0) count_pin_a = v; else count_pin_b = v;
    repeat (gap) @(posedge sys_clk);
  endtask : drive
  // Each level is held at least two cycles, slower when asked, so every fall is seen once.
  task automatic falls(input int pin, input int n, input int gap);
    repeat (n)
    begin
      drive(pin, 1'b0, gap);
      drive(pin, 1'b1, gap);
    end
  endtask : falls
endmodule : dtc_pin_model

// *** tb/dual_timer_counter_control_test.sv ***
// Self-checking bench for the dual timer/counter control block.
`timescale 1ns/1ps
module dual_timer_counter_control_test;
  logic       sys_clk;
  logic       rst;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       pin_a;
  logic       pin_b;
  logic [1:0] irq_in;
  logic [1:0] vec_t;
  logic [1:0] vec_x;
  logic       ext_clk_in;
  logic       sysclk_sel;
  logic [1:0] xflag;
  int         errors;
  int         n_checks;
  int         seed;
  int         hi;
  int         lo;
  int         flg;
  int         n;
  dtc_top u_dtc_top
  (
    .sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .count_pin_a(pin_a), .count_pin_b(pin_b),
    .ext_irq_a_input(irq_in[0]), .ext_irq_b_input(irq_in[1]), .ext_irq_a_polarity(1'b1),
    .ext_irq_b_polarity(1'b1), .prescale_select(dtc_pkg::DTC_PRE_DIV4),
    .timer_a_sysclk_select(sysclk_sel), .timer_b_sysclk_select(1'b0), .ext_clk_in(ext_clk_in),
    .vector_timer_a(vec_t[0]), .vector_timer_b(vec_t[1]), .vector_ext_irq_a(vec_x[0]),
    .vector_ext_irq_b(vec_x[1]), .timer_a_overflow_flag(), .timer_b_overflow_flag(),
    .ext_irq_a_flag(xflag[0]), .ext_irq_b_flag(xflag[1]), .timer_b_overflow_pulse()
  );
  dtc_pin_model u_dtc_pin_model(.sys_clk(sys_clk), .count_pin_a(pin_a), .count_pin_b(pin_b));
  // ****************************************
  // Bus tasks and reference model
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    ext_clk_in = 1'b0;
    forever #37 ext_clk_in = ~ext_clk_in;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input int a, input int d);
    @(posedge sys_clk);
    #1 {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a[7:0], d[7:0]};
    @(posedge sys_clk);
    #1 sfr_wr = 1'b0;
  endtask : wr
  task automatic rdx(input int a, input int exp, input string what);
    @(posedge sys_clk);
    #1 {sfr_rd, sfr_addr} = {1'b1, a[7:0]};
    @(posedge sys_clk);
    #1 sfr_rd = 1'b0;
    chk(what, sfr_rdata, exp[7:0]);
  endtask : rdx
  task automatic pulse(input int t, input logic ext);
    @(posedge sys_clk);
    #1 if (ext) vec_x[t] = 1'b1; else vec_t[t] = 1'b1;
    @(posedge sys_clk);
    #1 {vec_x, vec_t} = 4'h0;
  endtask : pulse
  // Mode 3 of timer B leaves the count alone, so no branch handles it.
  task automatic model_inc(input int m, input int k);
    int c;
    repeat (k)
    begin
      c = (m == 0) ? (((hi << 5) | (lo & 31)) + 1) : (((hi << 8) | lo) + 1);
      if (m == 0)
      begin
        flg |= (c == 8192);
        hi = (c >> 5) & 255;
        lo = (lo & 224) | (c & 31);
      end
      else if (m == 1)
      begin
        flg |= (c == 65536);
        hi = (c >> 8) & 255;
        lo = c & 255;
      end
      else if (m == 2)
      begin
        lo = lo + 1;
        flg |= (lo == 256);
        if (lo == 256) lo = hi;
      end
    end
  endtask : model_inc
  task automatic tally_and_finish;
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    seed = 32'hADEA8F1E;
    {rst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {1'b1, 18'h00000};
    {irq_in, vec_t, vec_x, sysclk_sel} = 7'h00;
    repeat (12) @(posedge sys_clk);
    #1 rst = 1'b0;
    for (int a = 'h88; a <= 'h8E; a++) rdx(a, 0, "reset or unmapped");
    for (int a = 'h8A; a <= 'h8D; a++)
    begin
      lo = $random(seed) & 255;
      wr(a, lo);
      rdx(a, lo, "count byte");
    end
    // modes 0 to 2 of each timer counted from pin falls near the wrap, plus timer B in mode 3.
    for (int t = 0; t < 2; t++)
      for (int m = 0; m < 3 + t; m++)
      begin
        {hi, lo, flg} = {32'd255, 32'd253, 32'd0};
        n = ($random(seed) & 3) + 2;
        wr('h89, (4 | m) << (4 * t));
        wr('h8C + t, hi);
        wr('h8A + t, lo);
        wr('h88, 16 << (2 * t));
        u_dtc_pin_model.falls(t, n, ($random(seed) & 3) + 2);
        model_inc(m, n);
        rdx('h8A + t, lo, "count low");
        rdx('h8C + t, hi, "count high");
        rdx('h88, (flg << (5 + 2 * t)) | (16 << (2 * t)), "overflow");
        pulse(t, 1'b0);
        rdx('h88, 16 << (2 * t), "vector clear");
        wr('h88, 32 << (2 * t));
        u_dtc_pin_model.falls(t, 1, 2);
        rdx('h8A + t, lo, "stopped");
      end
    // gate holds the count while the input is inactive.
    for (int t = 0; t < 2; t++)
    begin
      wr('h8A + t, 0);
      wr('h89, 12 << (4 * t));
      wr('h88, 16 << (2 * t));
      u_dtc_pin_model.falls(t, 3, 3);
      rdx('h8A + t, 0, "gated off");
      irq_in[t] = 1'b1;
      u_dtc_pin_model.falls(t, 3, 3);
      rdx('h8A + t, 3, "gated on");
      irq_in[t] = 1'b0;
      repeat (5) @(posedge sys_clk);
      wr('h88, 1 << (2 * t));
      irq_in[t] = 1'b1;
      repeat (6) @(posedge sys_clk);
      rdx('h88, 3 << (2 * t), "edge flag");
      chk("irq flag pin", {6'h00, xflag}, 8'h01 << t);
      pulse(t, 1'b1);
      rdx('h88, 1 << (2 * t), "edge vector");
      wr('h88, 0);
      rdx('h88, 2 << (2 * t), "level flag");
      irq_in[t] = 1'b0;
      repeat (5) @(posedge sys_clk);
      wr('h88, 0);
      rdx('h88, 0, "level off");
    end
    // split high byte runs on the other run bit and sets its flag.
    sysclk_sel = 1'b1;
    wr('h89, 3);
    wr('h8C, 'hF0);
    wr('h88, 'h40);
    // The second write lands on the edge at which the high byte wraps.
    repeat (14) @(posedge sys_clk);
    wr('h88, 'h40);
    rdx('h88, 'hC0, "split flag");
    tally_and_finish();
  end
endmodule : dual_timer_counter_control_test
